// File: rrse_exec.sv
// Execution unit for the conditional and subroutine returns, the word
// rotate and the register save, with a small control and event block.
// Assumes the core register file answers reg_rdata in the same cycle
// as reg_idx, and memory answers a read two cycles after start.
`timescale 1ns/1ps

module rrse_exec
    import rrse_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic start,
    input rrse_cmd_s cmd,
    input rrse_flags_s flags_in,
    input wire logic [31:0] stack_pointer,
    input wire logic [31:0] frame_pointer,
    input wire logic [31:0] reg_rdata,
    input wire logic [31:0] mem_rdata,
    input rrse_bus_s bus,
    output logic [31:0] bus_rdata,
    output logic irq,
    output logic busy,
    output rrse_mem_s mem,
    output logic [3:0] reg_idx,
    output logic pc_load,
    output logic [31:0] pc_val,
    output logic dst_we,
    output logic [31:0] dst_val,
    output logic flags_we,
    output rrse_flags_s flags_out,
    output logic spfp_we,
    output logic [31:0] sp_val,
    output logic [31:0] fp_val,
    output logic illegal_opnd,
    output logic done
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        rrse_state_e st;
        rrse_mem_s mem;
        logic [3:0] reg_idx;
        logic [31:0] wr_ptr;
        logic [31:0] sp_base;
        logic pc_load;
        logic [31:0] pc_val;
        logic dst_we;
        logic [31:0] dst_val;
        logic flags_we;
        rrse_flags_s flags;
        logic spfp_we;
        logic [31:0] sp_val;
        logic illegal;
        logic done;
        logic ctrl_en;
        logic [EV_W-1:0] status;
        logic [EV_W-1:0] mask;
        logic [31:0] rdata;
        logic [7:0] last_op;
    } rrse_core_s;

    rrse_core_s cur;
    rrse_core_s next_cur;
    logic [31:0] rot_result;
    rrse_flags_s rot_flags;
    logic accept;
    logic [EV_W-1:0] ev;

    // Return opcodes: 2 = not a return, 1 = taken, 0 = skipped
    function automatic logic [1:0] ret_decode(input logic [7:0] op, input rrse_flags_s f);
        logic [1:0] r;
        r = 2'h2;
        case (op)
            OP_RET_NE_S, OP_RET_NE_U: r = {1'b0, ~f.z};
            OP_SUB_RET: r = 2'h1;
            OP_RET_VC: r = {1'b0, ~f.v};
            OP_RET_VS: r = {1'b0, f.v};
            default: r = 2'h2;
        endcase
        return r;
    endfunction : ret_decode

    rrse_rotate u_rot (
        .src(cmd.src),
        .count(cmd.count),
        .result(rot_result),
        .flags(rot_flags)
    );

    assign accept = start && (cur.st == ST_IDLE) && cur.ctrl_en;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        ev = EV_RESET;
        next_cur.mem.rd = 1'b0;
        next_cur.mem.wr = 1'b0;
        next_cur.pc_load = 1'b0;
        next_cur.dst_we = 1'b0;
        next_cur.flags_we = 1'b0;
        next_cur.spfp_we = 1'b0;
        next_cur.illegal = 1'b0;
        next_cur.done = 1'b0;
        case (cur.st)
            ST_IDLE: begin
                if (accept) begin
                    next_cur.last_op = cmd.opcode;
                    if (ret_decode(cmd.opcode, flags_in) == 2'h1) begin
                        // Flags untouched on every return path
                        next_cur.mem.rd = 1'b1;
                        next_cur.mem.addr = stack_pointer;
                        next_cur.st = ST_RET_RD;
                    end else if (ret_decode(cmd.opcode, flags_in) == 2'h0) begin
                        next_cur.done = 1'b1;
                    end else if (cmd.opcode == OP_ROTATE) begin
                        if (cmd.dst_lit_imm) begin
                            next_cur.illegal = 1'b1;
                            ev[EV_ILLEGAL] = 1'b1;
                        end else begin
                            next_cur.dst_we = 1'b1;
                            next_cur.dst_val = rot_result;
                            next_cur.flags_we = 1'b1;
                            next_cur.flags = rot_flags;
                        end
                        next_cur.done = 1'b1;
                    end else if (cmd.opcode == OP_SAVE) begin
                        if (cmd.opnd_expanded) begin
                            next_cur.illegal = 1'b1;
                            ev[EV_ILLEGAL] = 1'b1;
                            next_cur.done = 1'b1;
                        end else begin
                            next_cur.mem.wr = 1'b1;
                            next_cur.mem.addr = stack_pointer;
                            next_cur.mem.wdata = frame_pointer;
                            next_cur.sp_base = stack_pointer;
                            next_cur.wr_ptr = stack_pointer + WORD_BYTES;
                            next_cur.reg_idx = cmd.reg_n;
                            // Out-of-range n or a non-register operand pushes only the
                            // frame pointer; small n runs past the save area
                            if (cmd.opnd_reg_mode && (cmd.reg_n < SAVE_END_REG)) begin
                                next_cur.st = ST_SAVE;
                            end else begin
                                next_cur.st = ST_SAVE_FIN;
                            end
                        end
                    end else begin
                        next_cur.done = 1'b1;
                    end
                end
            end
            ST_RET_RD: begin
                next_cur.st = ST_RET_WT;
            end
            ST_RET_WT: begin
                next_cur.pc_load = 1'b1;
                next_cur.pc_val = mem_rdata;
                next_cur.done = 1'b1;
                ev[EV_RET_TAKEN] = 1'b1;
                next_cur.st = ST_IDLE;
            end
            ST_SAVE: begin
                next_cur.mem.wr = 1'b1;
                next_cur.mem.addr = cur.wr_ptr;
                next_cur.mem.wdata = reg_rdata;
                next_cur.wr_ptr = cur.wr_ptr + WORD_BYTES;
                if (cur.reg_idx == SAVE_LAST_REG) begin
                    next_cur.st = ST_SAVE_FIN;
                end else begin
                    next_cur.reg_idx = cur.reg_idx + 4'h1;
                end
            end
            ST_SAVE_FIN: begin
                next_cur.spfp_we = 1'b1;
                next_cur.sp_val = cur.sp_base + SAVE_AREA_BYTES;
                next_cur.done = 1'b1;
                ev[EV_SAVE_DONE] = 1'b1;
                next_cur.st = ST_IDLE;
            end
            default: begin
                next_cur.st = ST_IDLE;
            end
        endcase

        // Register bus; an event in the clearing cycle survives the clear
        next_cur.rdata = 32'h00000000;
        if (bus.wr) begin
            case (bus.addr)
                ADDR_CTRL: next_cur.ctrl_en = bus.wdata[CTRL_EN_BIT];
                ADDR_STATUS: next_cur.status = cur.status & ~bus.wdata[EV_W-1:0];
                ADDR_MASK: next_cur.mask = bus.wdata[EV_W-1:0];
                default: next_cur.ctrl_en = cur.ctrl_en;
            endcase
        end
        next_cur.status = next_cur.status | ev;
        if (bus.rd) begin
            case (bus.addr)
                ADDR_CTRL: next_cur.rdata = {31'h00000000, cur.ctrl_en};
                ADDR_STATUS: next_cur.rdata = {29'h00000000, cur.status};
                ADDR_MASK: next_cur.rdata = {29'h00000000, cur.mask};
                ADDR_STATE: next_cur.rdata = {20'h00000, cur.last_op, 1'b0, cur.st};
                default: next_cur.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cur <= '0;
            cur.st <= ST_IDLE;
            cur.ctrl_en <= CTRL_EN_RESET;
            cur.status <= EV_RESET;
            cur.mask <= EV_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign bus_rdata = cur.rdata;
    assign irq = |(cur.status & cur.mask);
    assign busy = (cur.st != ST_IDLE);
    assign mem = cur.mem;
    assign reg_idx = cur.reg_idx;
    assign pc_load = cur.pc_load;
    assign pc_val = cur.pc_val;
    assign dst_we = cur.dst_we;
    assign dst_val = cur.dst_val;
    assign flags_we = cur.flags_we;
    assign flags_out = cur.flags;
    assign spfp_we = cur.spfp_we;
    assign sp_val = cur.sp_val;
    assign fp_val = cur.sp_val;
    assign illegal_opnd = cur.illegal;
    assign done = cur.done;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [3:0] save_wr_cnt;
    logic [3:0] save_n;
    logic save_regs;
    logic [31:0] exp_rot;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            save_wr_cnt <= 4'h0;
            save_n <= 4'h0;
            save_regs <= 1'b0;
        end else if (accept) begin
            save_wr_cnt <= 4'h0;
            save_n <= cmd.reg_n;
            save_regs <= cmd.opnd_reg_mode && (cmd.reg_n < SAVE_END_REG);
        end else if (cur.mem.wr) begin
            save_wr_cnt <= save_wr_cnt + 4'h1;
        end
    end

    assign exp_rot = 32'(({cmd.src, cmd.src} >> cmd.count[4:0]) & 64'h00000000FFFFFFFF);

    sequence ret_fetch_s;
        mem.rd && !pc_load ##1 !mem.rd ##1 pc_load && done;
    endsequence

    sequence one_shot_done_s;
        done && !mem.rd && !pc_load;
    endsequence

    ret_ne_a: assert property (@(posedge core_clk) disable iff (!nrst)
        accept && (cmd.opcode == OP_RET_NE_S || cmd.opcode == OP_RET_NE_U) && !flags_in.z
        |-> ##1 ret_fetch_s) else $error("not-equal return did not load pc");

    ret_skip_a: assert property (@(posedge core_clk) disable iff (!nrst)
        accept && (cmd.opcode == OP_RET_VC) && flags_in.v
        |-> ##1 one_shot_done_s ##1 !pc_load) else $error("overflow-clear return taken");

    ret_vs_a: assert property (@(posedge core_clk) disable iff (!nrst)
        accept && (cmd.opcode == OP_RET_VS) && flags_in.v
        |-> ##1 ret_fetch_s) else $error("overflow-set return not taken");

    rsb_pc_a: assert property (@(posedge core_clk) disable iff (!nrst)
        accept && (cmd.opcode == OP_SUB_RET)
        |-> ##1 (mem.addr == $past(stack_pointer)) ##2 (pc_val == $past(mem_rdata)))
        else $error("subroutine return pc wrong");

    rot_val_a: assert property (@(posedge core_clk) disable iff (!nrst)
        accept && (cmd.opcode == OP_ROTATE) && !cmd.dst_lit_imm
        |=> dst_we && (dst_val == $past(exp_rot))) else $error("rotate value wrong");

    rot_flag_a: assert property (@(posedge core_clk) disable iff (!nrst)
        flags_we |-> dst_we && (flags_out.n == dst_val[31])
        && (flags_out.z == (dst_val == 32'h00000000)) && !flags_out.c && !flags_out.v)
        else $error("rotate flags wrong");

    rot_ill_a: assert property (@(posedge core_clk) disable iff (!nrst)
        accept && (cmd.opcode == OP_ROTATE) && cmd.dst_lit_imm
        |=> illegal_opnd && !dst_we && irq == |(cur.mask & 3'h1))
        else $error("rotate literal destination not refused");

    flag_keep_a: assert property (@(posedge core_clk) disable iff (!nrst)
        flags_we |-> $past(cmd.opcode) == OP_ROTATE && $past(accept))
        else $error("flags written outside rotate");

    save_cnt_a: assert property (@(posedge core_clk) disable iff (!nrst)
        spfp_we |-> save_wr_cnt == (save_regs ? (4'hA - save_n) : 4'h1))
        else $error("save pushed wrong number of words");

    save_sp_a: assert property (@(posedge core_clk) disable iff (!nrst)
        spfp_we |-> (sp_val == fp_val) && (sp_val == cur.sp_base + SAVE_AREA_BYTES))
        else $error("save pointer update wrong");

    save_ill_a: assert property (@(posedge core_clk) disable iff (!nrst)
        accept && (cmd.opcode == OP_SAVE) && cmd.opnd_expanded
        |=> illegal_opnd && !mem.wr ##1 !spfp_we) else $error("expanded save not refused");

endmodule : rrse_exec

// File: rrse_pkg.sv
// Constants, carriers and the state enumeration for the return, rotate
// and register-save execution block.
// Assumes one 200 MHz core clock and an active-low asynchronous reset.
package rrse_pkg;

    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_RET_NE_S = 8'h74;
    localparam logic [7:0] OP_RET_NE_U = 8'h64;
    localparam logic [7:0] OP_ROTATE = 8'hD8;
    localparam logic [7:0] OP_SUB_RET = 8'h78;
    localparam logic [7:0] OP_RET_VC = 8'h60;
    localparam logic [7:0] OP_RET_VS = 8'h68;
    localparam logic [7:0] OP_SAVE = 8'h10;

    // ------------------------------------------------------------
    // Arithmetic constants
    // ------------------------------------------------------------
    localparam logic [4:0] ROT_MASK = 5'h1F;
    localparam logic [3:0] SAVE_LAST_REG = 4'h8;
    localparam logic [3:0] SAVE_END_REG = 4'h9;
    localparam logic [31:0] SAVE_AREA_BYTES = 32'h0000001C;
    localparam logic [31:0] WORD_BYTES = 32'h00000004;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [7:0] ADDR_STATE = 8'h0C;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RESET = 1'b1;
    localparam int EV_ILLEGAL = 0;
    localparam int EV_RET_TAKEN = 1;
    localparam int EV_SAVE_DONE = 2;
    localparam int EV_W = 3;
    localparam logic [EV_W-1:0] EV_RESET = 3'h0;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } rrse_flags_s;

    typedef struct packed {
        logic [7:0] opcode;
        logic [31:0] count;
        logic [31:0] src;
        logic dst_lit_imm;
        logic opnd_reg_mode;
        logic opnd_expanded;
        logic [3:0] reg_n;
    } rrse_cmd_s;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [31:0] addr;
        logic [31:0] wdata;
    } rrse_mem_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } rrse_bus_s;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RET_RD,
        ST_RET_WT,
        ST_SAVE,
        ST_SAVE_FIN
    } rrse_state_e;

endpackage : rrse_pkg

// File: rrse_rotate.sv
// Word rotator with the condition flags that a rotate produces.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps

module rrse_rotate
    import rrse_pkg::*;
(
    input wire logic [31:0] src,
    input wire logic [31:0] count,
    output logic [31:0] result,
    output rrse_flags_s flags
);

    logic [4:0] amt;
    logic [63:0] dbl;

    always_comb begin
        amt = count[4:0] & ROT_MASK;
        dbl = {src, src} >> amt;
        result = dbl[31:0];
        flags.n = result[31];
        flags.z = (result == 32'h00000000);
        flags.c = 1'b0;
        flags.v = 1'b0;
    end

endmodule : rrse_rotate

// File: rrse_testbench.sv
// Self-checking bench for the return, rotate and register-save unit.
// Assumes testbench as top with rrse_exec inside; the bench plays register file, memory and host.
`timescale 1ns/1ps

module testbench;
    import rrse_pkg::*;

    typedef struct packed {
        logic [7:0] op;
        logic [3:0] flg;
        logic [31:0] count;
        logic [31:0] src;
        logic lit;
    } rrse_row_s;

    logic core_clk, nrst, start, irq, busy, pc_load, dst_we, flags_we, spfp_we;
    logic illegal_opnd, done, tk;
    logic [3:0] reg_idx;
    logic [31:0] stack_pointer, frame_pointer, reg_rdata, mem_rdata, bus_rdata, pc_val;
    logic [31:0] dst_val, sp_val, fp_val, rd, exp_v, got_pc, got_dst, got_sp, got_fp;
    rrse_cmd_s cmd, rc;
    rrse_flags_s flags_in, flags_out, got_flg;
    rrse_bus_s bus;
    rrse_mem_s mem;
    rrse_row_s rows [13];
    int num_errors, total_checks, cycles, n_pc, n_dst, n_flg, n_ill, n_wr, n_spfp, k;
    int ns [5] = '{3, 7, 9, 0, 1};

    rrse_exec dut (.core_clk(core_clk), .nrst(nrst), .start(start), .cmd(cmd),
        .flags_in(flags_in), .stack_pointer(stack_pointer), .frame_pointer(frame_pointer),
        .reg_rdata(reg_rdata), .mem_rdata(mem_rdata), .bus(bus), .bus_rdata(bus_rdata),
        .irq(irq), .busy(busy), .mem(mem), .reg_idx(reg_idx), .pc_load(pc_load),
        .pc_val(pc_val), .dst_we(dst_we), .dst_val(dst_val), .flags_we(flags_we),
        .flags_out(flags_out), .spfp_we(spfp_we), .sp_val(sp_val), .fp_val(fp_val),
        .illegal_opnd(illegal_opnd), .done(done));

    // ------------------------------------------------------------
    // Register file model and helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] regv(input logic [3:0] i);
        return 32'hC0DE0000 | {28'h0000000, i};
    endfunction : regv

    assign reg_rdata = regv(reg_idx);

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    task automatic bwr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask : bwr

    task automatic brd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1 d = bus_rdata;
    endtask : brd

    // One command from start to done; pulses are tallied in the cycle they stand
    task automatic run(input rrse_cmd_s c, input rrse_flags_s f, input logic [31:0] sp,
        input logic [31:0] fp, input logic [31:0] md);
        int i;
        n_pc = 0; n_dst = 0; n_flg = 0; n_ill = 0; n_wr = 0; n_spfp = 0;
        @(posedge core_clk);
        start <= 1'b1;
        cmd <= c;
        flags_in <= f;
        stack_pointer <= sp;
        frame_pointer <= fp;
        mem_rdata <= md;
        @(posedge core_clk);
        start <= 1'b0;
        for (i = 1; i <= 40; i++) begin
            #1;
            if (pc_load === 1'b1) begin n_pc++; got_pc = pc_val; end
            if (dst_we === 1'b1) begin n_dst++; got_dst = dst_val; end
            if (flags_we === 1'b1) begin n_flg++; got_flg = flags_out; end
            if (illegal_opnd === 1'b1) n_ill++;
            if (spfp_we === 1'b1) begin n_spfp++; got_sp = sp_val; got_fp = fp_val; end
            if (mem.rd === 1'b1) chk(mem.addr, sp, "return read address");
            if (mem.wr === 1'b1) begin
                chk(mem.addr, sp + 32'(4 * n_wr), "save address");
                chk(mem.wdata, n_wr == 0 ? fp : regv(4'(c.reg_n + n_wr - 1)), "save data");
                n_wr++;
            end
            if (done === 1'b1) break;
            @(posedge core_clk);
        end
        cycles = i;
    endtask : run

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        nrst = 1'b0; start = 1'b0; cmd = '0; flags_in = '0; bus = '0;
        stack_pointer = '0; frame_pointer = '0; mem_rdata = '0;
        rows = '{'{8'h74, 4'h0, 32'h0, 32'h0, 1'b0}, '{8'h74, 4'h4, 32'h0, 32'h0, 1'b0},
            '{8'h64, 4'hB, 32'h0, 32'h0, 1'b0}, '{8'h64, 4'hF, 32'h0, 32'h0, 1'b0},
            '{8'h78, 4'h4, 32'h0, 32'h0, 1'b0}, '{8'h60, 4'h0, 32'h0, 32'h0, 1'b0},
            '{8'h60, 4'h1, 32'h0, 32'h0, 1'b0}, '{8'h68, 4'h1, 32'h0, 32'h0, 1'b0},
            '{8'h68, 4'hE, 32'h0, 32'h0, 1'b0}, '{8'hD8, 4'h0, 32'h404, 32'h0F00007E, 1'b0},
            '{8'hD8, 4'hF, 32'hFFFFFFE0, 32'h12345678, 1'b0},
            '{8'hD8, 4'h0, 32'h1F, 32'h1, 1'b1}, '{8'h00, 4'hF, 32'h0, 32'h0, 1'b0}};
        repeat (4) @(posedge core_clk);
        #1 chk(busy, 1'b0, "busy in reset");
        chk(irq, 1'b0, "irq in reset");
        @(posedge core_clk);
        nrst <= 1'b1;
        brd(ADDR_CTRL, rd); chk(rd, 32'h1, "ctrl reset");
        brd(ADDR_STATUS, rd); chk(rd, 32'h0, "status reset");
        brd(ADDR_MASK, rd); chk(rd, 32'h0, "mask reset");
        // Ordinary cases from the table
        for (int r = 0; r < 13; r++) begin
            rc = '0;
            rc.opcode = rows[r].op;
            rc.count = rows[r].count;
            rc.src = rows[r].src;
            rc.dst_lit_imm = rows[r].lit;
            case (rows[r].op)
                8'h74, 8'h64: tk = ~rows[r].flg[2];
                8'h78: tk = 1'b1;
                8'h60: tk = ~rows[r].flg[0];
                8'h68: tk = rows[r].flg[0];
                default: tk = 1'b0;
            endcase
            run(rc, rows[r].flg, 32'h00008000 + 32'(16 * r), 32'h0, 32'h10000000 + 32'(r));
            chk(n_pc, tk, "return taken");
            if (tk) chk(got_pc, 32'h10000000 + 32'(r), "pc value");
            chk(cycles, tk ? 3 : 1, "command length");
            if (rows[r].op != OP_ROTATE) begin
                chk(n_flg, 0, "flags written");
                chk(n_ill, 0, "return exception");
            end else if (rows[r].lit) begin
                chk(n_ill, 1, "literal destination");
                chk(n_dst, 0, "literal destination write");
            end else begin
                exp_v = 32'({rows[r].src, rows[r].src} >> rows[r].count[4:0]);
                chk(got_dst, exp_v, "rotate result");
                chk(got_flg, {exp_v[31], exp_v == 32'h0, 2'b00}, "rotate flags");
            end
        end
        // Register save over the edge values of n
        for (int j = 0; j < 5; j++) begin
            rc = '0;
            rc.opcode = OP_SAVE;
            rc.opnd_reg_mode = 1'b1;
            rc.reg_n = 4'(ns[j]);
            run(rc, 4'h5, 32'h00010000, 32'h0000F000, 32'h0);
            k = 9 - ns[j];
            chk(n_wr, k + 1, "save word count");
            chk(got_sp, 32'h0001001C, "save stack pointer");
            chk(got_fp, 32'h0001001C, "save frame pointer");
            chk(cycles, k + 2, "save length");
            chk(n_flg, 0, "save flags");
        end
        rc.opnd_expanded = 1'b1;
        rc.reg_n = 4'h3;
        run(rc, 4'h0, 32'h00010000, 32'h0000F000, 32'h0);
        chk(n_ill, 1, "expanded operand");
        chk(n_wr, 0, "expanded operand writes");
        chk(n_spfp, 0, "expanded operand pointers");
        // Events, mask and level interrupt
        bwr(ADDR_STATUS, 32'h7);
        brd(ADDR_STATUS, rd); chk(rd, 32'h0, "status cleared");
        rc = '0;
        rc.opcode = OP_SUB_RET;
        run(rc, 4'h0, 32'h00020000, 32'h0, 32'h12345678);
        brd(ADDR_STATUS, rd); chk(rd, 32'h2, "return event");
        brd(ADDR_STATE, rd); chk(rd, {20'h00000, OP_SUB_RET, 4'h0}, "state register");
        chk(irq, 1'b0, "irq masked");
        bwr(ADDR_MASK, 32'h2);
        @(posedge core_clk);
        #1 chk(irq, 1'b1, "irq unmasked");
        bwr(ADDR_STATUS, 32'h2);
        @(posedge core_clk);
        #1 chk(irq, 1'b0, "irq cleared");
        brd(8'h40, rd); chk(rd, 32'h0, "unmapped read");
        bwr(8'h40, 32'hFFFFFFFF);
        brd(ADDR_CTRL, rd); chk(rd, 32'h1, "unmapped write");
        // A disabled unit ignores start
        bwr(ADDR_CTRL, 32'h0);
        @(posedge core_clk);
        start <= 1'b1;
        cmd <= rc;
        @(posedge core_clk);
        start <= 1'b0;
        n_pc = 0;
        repeat (5) begin
            #1 if (done === 1'b1 || pc_load === 1'b1 || busy === 1'b1) n_pc++;
            @(posedge core_clk);
        end
        chk(n_pc, 0, "disabled start");
        bwr(ADDR_CTRL, 32'h1);
        test_done();
    end

    initial begin
        #100000;
        num_errors++;
        test_done();
    end

endmodule : testbench
